// ### test/framer_loopback_switching_tb_top.sv
// Self-checking bench of the framer loopback switch.
// Assumes line_side_model on the far side and a 25 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module framer_loopback_switching_tb_top
	import loopback_pkg::*;
;
	typedef struct {
		logic [7:0] cfg;
		logic [7:0] transmit_framing_control;
		logic       rem;
		logic       ovh;
		logic [1:0] sel;
	} row_t;
	row_t       rows [7] = '{'{8'h00, 8'h00, 1'b0, 1'b0, 2'd1}, '{8'h04, 8'h00, 1'b0, 1'b0, 2'd2},
		'{8'h00, 8'h00, 1'b1, 1'b0, 2'd2}, '{8'h04, 8'h00, 1'b1, 1'b0, 2'd2},
		'{8'h04, 8'h00, 1'b0, 1'b1, 2'd0}, '{8'h04, 8'h01, 1'b0, 1'b1, 2'd1},
		'{8'h00, 8'h00, 1'b0, 1'b0, 2'd1}};
	logic       clk = 1'b0;
	logic       rst_n, reg_cs, reg_wr, reg_rd, rx_line_pos, rx_line_neg, rx_line_clk;
	logic       enc_pos, enc_neg, enc_stb, tx_line_pos_ff, tx_line_neg_ff, tx_line_stb_ff;
	logic       dec_pos_ff, dec_neg_ff, dec_stb_ff, rx_slot_valid, rx_frame_end, tx_req_valid;
	logic       tx_slot_valid_ff, sys_rx_valid, sys_rx_ready_ff, rsb_valid_ff, rsb_ready;
	logic       reg_rvalid_ff, run, stall;
	logic [8:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata_ff, rx_slot_byte, tx_slot_byte_ff, tsb_pcm, rises;
	logic [7:0] stb_n = 8'h00, s0, r0, lb, f, s;
	logic [3:0] tsb_sig;
	logic [4:0] rx_slot_num, n;
	tx_req_t    tx_req;
	rsb_word_t  sys_rx_word, rsb_word_ff, w, e;
	rsb_word_t  exp_q [$];
	int         miscompares = 0, n_tests = 0, got_n = 0;

	always #20 clk = ~clk;

	framer_loopback_switching i_framer_loopback_switching (.clk(clk), .rst_n(rst_n),
		.reg_cs(reg_cs), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
		.rx_line_pos(rx_line_pos), .rx_line_neg(rx_line_neg), .rx_line_clk(rx_line_clk),
		.enc_pos(enc_pos), .enc_neg(enc_neg), .enc_stb(enc_stb),
		.tx_line_pos_ff(tx_line_pos_ff), .tx_line_neg_ff(tx_line_neg_ff),
		.tx_line_stb_ff(tx_line_stb_ff), .dec_pos_ff(dec_pos_ff), .dec_neg_ff(dec_neg_ff),
		.dec_stb_ff(dec_stb_ff), .rx_slot_valid(rx_slot_valid), .rx_slot_num(rx_slot_num),
		.rx_slot_byte(rx_slot_byte), .rx_frame_end(rx_frame_end),
		.tx_req_valid(tx_req_valid), .tx_req(tx_req), .tx_slot_valid_ff(tx_slot_valid_ff),
		.tx_slot_byte_ff(tx_slot_byte_ff), .sys_rx_valid(sys_rx_valid),
		.sys_rx_word(sys_rx_word), .tsb_pcm(tsb_pcm), .tsb_sig(tsb_sig),
		.sys_rx_ready_ff(sys_rx_ready_ff), .rsb_valid_ff(rsb_valid_ff),
		.rsb_ready(rsb_ready), .rsb_word_ff(rsb_word_ff));

	line_side_model i_line_side_model (.run(run), .stall(stall), .rx_line_clk(rx_line_clk),
		.rsb_ready(rsb_ready), .rises(rises));

	always @(posedge clk) begin
		if (tx_line_stb_ff === 1'b1) stb_n <= stb_n + 8'h01;
		if (rsb_valid_ff === 1'b1 && rsb_ready === 1'b1 && exp_q.size() > 0) begin
			`CHK(rsb_word_ff, exp_q[0])
			void'(exp_q.pop_front());
			got_n++;
		end
	end

	task close_out;
		if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task reg_write(input logic [8:0] a, input logic [7:0] d);
		@(negedge clk);
		{reg_cs, reg_wr, reg_addr, reg_wdata} = {2'b11, a, d};
		@(negedge clk);
		{reg_cs, reg_wr} = 2'b00;
	endtask

	task reg_read(input logic [8:0] a, input logic [7:0] d);
		@(negedge clk);
		{reg_cs, reg_rd, reg_addr} = {2'b11, a};
		@(negedge clk);
		{reg_cs, reg_rd} = 2'b00;
		// Answer stands one cycle, two edges after the request edge
		@(negedge clk);
		`CHK(reg_rvalid_ff, 1'b1)
		`CHK(reg_rdata_ff, d)
	endtask

	task rx_slot(input logic [4:0] num, input logic [7:0] b, input logic last);
		@(negedge clk);
		{rx_slot_valid, rx_slot_num, rx_slot_byte, rx_frame_end} = {1'b1, num, b, last};
		@(negedge clk);
		{rx_slot_valid, rx_frame_end} = 2'b00;
	endtask

	task push(input rsb_word_t pw, input logic [7:0] p, input logic [3:0] g);
		int k;
		@(negedge clk);
		{sys_rx_valid, sys_rx_word, tsb_pcm, tsb_sig} = {1'b1, pw, p, g};
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (sys_rx_ready_ff !== 1'b1 && k < 50);
		if (k >= 50) begin
			miscompares++;
			close_out();
		end
	endtask

	task line_check(input logic [7:0] cfg, input logic tx_rx, input logic dec_rx);
		reg_write(LOOP_CFG_OFS, cfg);
		repeat (5) @(negedge clk);
		`CHK(tx_line_pos_ff, tx_rx)
		`CHK(dec_pos_ff, dec_rx)
		`CHK(dec_neg_ff, ~dec_rx)
		`CHK(dec_stb_ff, 1'b0)
	endtask

	initial begin
		{rst_n, reg_cs, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{rx_line_pos, rx_line_neg, enc_pos, enc_neg, enc_stb} = 5'b10010;
		{rx_slot_valid, rx_slot_num, rx_slot_byte, rx_frame_end, tx_req_valid} = '0;
		{tx_req, sys_rx_valid, sys_rx_word, tsb_pcm, tsb_sig, run, stall} = '0;
		repeat (8) @(negedge clk);
		`CHK(sys_rx_ready_ff, 1'b0)
		rst_n = 1'b1;
		reg_read(LOOP_CFG_OFS, LOOP_CFG_RST);
		reg_read(TRANSMIT_FRAMING_CONTROL_OFS, TRANSMIT_FRAMING_CONTROL_RST);
		reg_read(SBC_BASE_OFS, CHAN_CTRL_RST);
		reg_read(TPC_LAST_OFS, CHAN_CTRL_RST);
		reg_write(SBC_LAST_OFS, 8'ha5);
		reg_read(SBC_LAST_OFS, 8'ha5);
		reg_write(9'h030, 8'hff);
		reg_read(9'h030, UNMAPPED_READ);
		for (int i = 0; i < 7; i++) begin
			n = 5'(i + 2);
			lb = 8'ha0 | 8'(i);
			f = 8'h50 | 8'(i);
			s = 8'h30 | 8'(i);
			reg_write(LOOP_CFG_OFS, rows[i].cfg);
			reg_write(TRANSMIT_FRAMING_CONTROL_OFS, rows[i].transmit_framing_control);
			reg_write(TPC_BASE_OFS + 9'(n), {7'h00, rows[i].rem});
			rx_slot(n, lb, 1'b0);
			rx_slot(n + 5'd1, ~lb, 1'b1);
			@(negedge clk);
			tx_req = '{num: n, overhead: rows[i].ovh, first: 1'b1, fmt_byte: f, sys_byte: s};
			tx_req_valid = 1'b1;
			@(negedge clk);
			tx_req_valid = 1'b0;
			@(negedge clk);
			`CHK(tx_slot_valid_ff, 1'b1)
			`CHK(tx_slot_byte_ff, rows[i].sel == 2'd0 ? f : rows[i].sel == 2'd1 ? s : lb)
		end
		line_check(8'h02, 1'b1, 1'b1);
		s0 = stb_n;
		r0 = rises;
		run = 1'b1;
		repeat (20) @(negedge clk);
		run = 1'b0;
		repeat (8) @(negedge clk);
		`CHK(8'(stb_n - s0), 8'(rises - r0))
		line_check(8'h01, 1'b0, 1'b0);
		line_check(8'h03, 1'b1, 1'b0);
		// AIS mark polarity flips once per transmitted strobe since reset
		line_check(8'h0a, stb_n[0], 1'b1);
		`CHK(tx_line_pos_ff ^ tx_line_neg_ff, 1'b1)
		line_check(8'h00, 1'b0, 1'b1);
		stall = 1'b1;
		for (int j = 0; j < 4; j++) begin
			reg_write(SBC_BASE_OFS + 9'(3 + j), 8'(j + 1));
		end
		for (int j = 0; j < 4; j++) begin
			w = '{slot: 5'(3 + j), pcm: 8'hc0 | 8'(j), sig: 4'h5};
			e = w;
			if (j[0] == 1'b0) e.pcm = 8'h90 | 8'(j);
			if (j[1:0] == 2'd1 || j[1:0] == 2'd2) e.sig = 4'ha;
			exp_q.push_back(e);
			push(w, 8'h90 | 8'(j), 4'ha);
			if (j == 1) begin
				@(negedge clk);
				sys_rx_valid = 1'b0;
				@(negedge clk);
				`CHK(sys_rx_ready_ff, 1'b0)
				stall = 1'b0;
			end
		end
		@(negedge clk);
		sys_rx_valid = 1'b0;
		repeat (6) @(negedge clk);
		`CHK(got_n, 4)
		close_out();
	end
endmodule

// ### test/line_side_model.sv
// Far-side model: receive line clock source and system receive word sink.
// Assumes the bench starts and stops the line clock and commands stalls.
`timescale 1ns/1ps
module line_side_model (
	input  wire logic       run,
	input  wire logic       stall,
	output logic            rx_line_clk,
	output logic            rsb_ready,
	output logic [7:0]      rises
);
	initial begin
		rx_line_clk = 1'b0;
		rises = 8'h00;
	end
	// Line clock stands low outside a run, phase unrelated to clk
	always #65 begin
		if (run || rx_line_clk) begin
			rx_line_clk = ~rx_line_clk;
			if (rx_line_clk) begin
				rises = rises + 8'h01;
			end
		end
	end
	assign rsb_ready = ~stall;
endmodule

// ### verilog/chan_byte_mem.sv
// Small byte memory: one write port, one read port with registered read data.
// Assumes synchronous active-low reset; contents clear to RESET_VAL.
`timescale 1ns/1ps
module chan_byte_mem #(
	parameter int         W         = 8,
	parameter int         DEPTH     = 64,
	parameter int         AW        = 6,
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W-1:0]  wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [W-1:0]  rd_data_ff
);
	logic [W-1:0] mem_ff [DEPTH];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= RESET_VAL[W-1:0];
			end
		end else if (wr_en) begin
			mem_ff[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_data_ff <= '0;
		end else begin
			rd_data_ff <= mem_ff[rd_addr];
		end
	end
endmodule

// ### verilog/framer_loopback_switching.sv
// Loopback switch of one framer: line, payload, framer and per-channel loops.
// Assumes line pins are asynchronous; encoder, slot streams and register port
// run on clk.
`timescale 1ns/1ps

module framer_loopback_switching
	import loopback_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              reg_cs,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [8:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	output logic      [7:0]        reg_rdata_ff,
	output logic                   reg_rvalid_ff,
	input  wire logic              rx_line_pos,
	input  wire logic              rx_line_neg,
	input  wire logic              rx_line_clk,
	input  wire logic              enc_pos,
	input  wire logic              enc_neg,
	input  wire logic              enc_stb,
	output logic                   tx_line_pos_ff,
	output logic                   tx_line_neg_ff,
	output logic                   tx_line_stb_ff,
	output logic                   dec_pos_ff,
	output logic                   dec_neg_ff,
	output logic                   dec_stb_ff,
	input  wire logic              rx_slot_valid,
	input  wire logic [SLOT_W-1:0] rx_slot_num,
	input  wire logic [7:0]        rx_slot_byte,
	input  wire logic              rx_frame_end,
	input  wire logic              tx_req_valid,
	input  wire tx_req_t           tx_req,
	output logic                   tx_slot_valid_ff,
	output logic      [7:0]        tx_slot_byte_ff,
	input  wire logic              sys_rx_valid,
	input  wire rsb_word_t         sys_rx_word,
	input  wire logic [7:0]        tsb_pcm,
	input  wire logic [3:0]        tsb_sig,
	output logic                   sys_rx_ready_ff,
	output logic                   rsb_valid_ff,
	input  wire logic              rsb_ready,
	output rsb_word_t              rsb_word_ff
);
	// Register port
	logic [7:0]         loop_cfg_ff;
	logic [7:0]         transmit_framing_control_ff;
	logic [SLOTS-1:0]   remote_loop_ff;
	logic [SLOTS-1:0]   pcm_loop_ff;
	logic [SLOTS-1:0]   sig_loop_ff;
	rd_src_t            rd_src_ff;
	logic               rd_p1_ff;
	logic [7:0]         chan_rdata;

	wire                wr_hit   = reg_cs & reg_wr;
	wire                rd_hit   = reg_cs & reg_rd;
	wire                is_loop  = (reg_addr == LOOP_CFG_OFS);
	wire                is_transmit_framing_control  = (reg_addr == TRANSMIT_FRAMING_CONTROL_OFS);
	wire                is_chan  = chan_hit(reg_addr);
	wire [CHAN_AW-1:0]  chan_idx = chan_index(reg_addr);
	wire                chan_wr  = wr_hit & is_chan;
	wire rd_src_t       rd_src   = is_loop ? SRC_LOOP : is_transmit_framing_control ? SRC_TRANSMIT_FRAMING_CONTROL :
	                               is_chan ? SRC_CHAN : SRC_NONE;

	chan_byte_mem #(
		.W         (8),
		.DEPTH     (CHAN_REGS),
		.AW        (CHAN_AW),
		.RESET_VAL (CHAN_CTRL_RST)
	) u_chan_regs (
		.clk        (clk),
		.rst_n      (rst_n),
		.wr_en      (chan_wr),
		.wr_addr    (chan_idx),
		.wr_data    (reg_wdata),
		.rd_addr    (chan_idx),
		.rd_data_ff (chan_rdata)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			loop_cfg_ff <= LOOP_CFG_RST;
			transmit_framing_control_ff     <= TRANSMIT_FRAMING_CONTROL_RST;
		end else if (wr_hit) begin
			if (is_loop) loop_cfg_ff <= reg_wdata;
			if (is_transmit_framing_control) transmit_framing_control_ff <= reg_wdata;
		end
	end

	// Channel enables are mirrored in flops so every slot sees them at once
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			remote_loop_ff <= '0;
			pcm_loop_ff    <= '0;
			sig_loop_ff    <= '0;
		end else if (chan_wr && chan_idx[CHAN_AW-1]) begin
			remote_loop_ff[chan_idx[SLOT_W-1:0]] <= reg_wdata[REMOTE_LOOP_BIT];
		end else if (chan_wr) begin
			pcm_loop_ff[chan_idx[SLOT_W-1:0]] <= reg_wdata[LOCAL_PCM_BIT];
			sig_loop_ff[chan_idx[SLOT_W-1:0]] <= reg_wdata[LOCAL_SIG_BIT];
		end
	end

	wire [7:0] rd_mux = (rd_src_ff == SRC_LOOP) ? loop_cfg_ff :
	                    (rd_src_ff == SRC_TRANSMIT_FRAMING_CONTROL) ? transmit_framing_control_ff :
	                    (rd_src_ff == SRC_CHAN) ? chan_rdata : UNMAPPED_READ;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_p1_ff      <= 1'b0;
			rd_src_ff     <= SRC_NONE;
			reg_rvalid_ff <= 1'b0;
			reg_rdata_ff  <= '0;
		end else begin
			rd_p1_ff      <= rd_hit;
			rd_src_ff     <= rd_src;
			reg_rvalid_ff <= rd_p1_ff;
			reg_rdata_ff  <= rd_p1_ff ? rd_mux : reg_rdata_ff;
		end
	end

	wire line_loop    = loop_cfg_ff[LINE_LOOP_BIT];
	wire framer_loop  = loop_cfg_ff[FRAMER_LOOP_BIT];
	wire payload_loop = loop_cfg_ff[PAYLOAD_LOOP_BIT];
	wire ais_on       = loop_cfg_ff[AIS_OVR_BIT];
	wire ovh_sys      = transmit_framing_control_ff[OVH_FROM_SYS_BIT];

	// Line side: pins pass two flops; third stage only for clock edge
	logic [2:0] rx_s1_ff;
	logic [2:0] rx_s2_ff;
	logic       rx_clk_s3_ff;
	logic       ais_phase_ff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_s1_ff     <= '0;
			rx_s2_ff     <= '0;
			rx_clk_s3_ff <= 1'b0;
		end else begin
			rx_s1_ff     <= {rx_line_clk, rx_line_pos, rx_line_neg};
			rx_s2_ff     <= rx_s1_ff;
			rx_clk_s3_ff <= rx_s2_ff[2];
		end
	end

	wire             rx_edge  = rx_s2_ff[2] & ~rx_clk_s3_ff;
	wire line_pair_t rx_pair  = rx_s2_ff[1:0];
	// AIS in bipolar form: alternating marks, one per looped bit
	wire line_pair_t ais_pair = '{pos: ais_phase_ff, neg: ~ais_phase_ff};
	wire line_pair_t looped   = ais_on ? ais_pair : rx_pair;
	wire             tx_stb   = line_loop ? rx_edge : enc_stb;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ais_phase_ff <= 1'b0;
		end else if (tx_stb) begin
			ais_phase_ff <= ~ais_phase_ff;
		end
	end

	// Transmit and decoder selects are independent, so both loops may coexist
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_line_pos_ff <= 1'b0;
			tx_line_neg_ff <= 1'b0;
			tx_line_stb_ff <= 1'b0;
			dec_pos_ff     <= 1'b0;
			dec_neg_ff     <= 1'b0;
			dec_stb_ff     <= 1'b0;
		end else begin
			tx_line_pos_ff <= line_loop ? looped.pos : enc_pos;
			tx_line_neg_ff <= line_loop ? looped.neg : enc_neg;
			tx_line_stb_ff <= tx_stb;
			dec_pos_ff     <= framer_loop ? enc_pos : rx_pair.pos;
			dec_neg_ff     <= framer_loop ? enc_neg : rx_pair.neg;
			dec_stb_ff     <= framer_loop ? enc_stb : rx_edge;
		end
	end

	// Payload loop: two-frame buffer; tx reads the last completed frame
	logic              wr_bank_ff;
	logic              rd_bank_ff;
	logic [7:0]        loop_rdata;
	logic              tx_p1_ff;
	logic              p1_ovh_ff;
	logic              p1_loop_ff;
	logic [7:0]        p1_fmt_ff;
	logic [7:0]        p1_sys_ff;

	wire               rd_bank   = tx_req.first ? ~wr_bank_ff : rd_bank_ff;
	wire [SLOT_W:0]    lb_wr_adr = {wr_bank_ff, rx_slot_num};
	wire [SLOT_W:0]    lb_rd_adr = {rd_bank, tx_req.num};
	wire               loop_sel  = payload_loop | remote_loop_ff[tx_req.num];

	chan_byte_mem #(
		.W         (8),
		.DEPTH     (2 * SLOTS),
		.AW        (SLOT_W + 1),
		.RESET_VAL (8'hff)
	) u_loop_buf (
		.clk        (clk),
		.rst_n      (rst_n),
		.wr_en      (rx_slot_valid),
		.wr_addr    (lb_wr_adr),
		.wr_data    (rx_slot_byte),
		.rd_addr    (lb_rd_adr),
		.rd_data_ff (loop_rdata)
	);

	// Frame-granular bank swap makes rate mismatch a whole-frame repeat or
	// drop; no slip error is raised for it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_bank_ff <= 1'b0;
			rd_bank_ff <= 1'b1;
		end else begin
			if (rx_slot_valid && rx_frame_end) wr_bank_ff <= ~wr_bank_ff;
			if (tx_req_valid && tx_req.first) rd_bank_ff <= ~wr_bank_ff;
		end
	end

	// Slot timing follows the formatter's requests; loop bits only steer data.
	// Signaling is not realigned to the multiframe here.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_p1_ff   <= 1'b0;
			p1_ovh_ff  <= 1'b0;
			p1_loop_ff <= 1'b0;
			p1_fmt_ff  <= '0;
			p1_sys_ff  <= '0;
		end else begin
			tx_p1_ff   <= tx_req_valid;
			p1_ovh_ff  <= tx_req.overhead;
			p1_loop_ff <= loop_sel;
			p1_fmt_ff  <= tx_req.fmt_byte;
			p1_sys_ff  <= tx_req.sys_byte;
		end
	end

	wire [7:0] ovh_byte = ovh_sys ? p1_sys_ff : p1_fmt_ff;
	wire [7:0] pay_byte = p1_loop_ff ? loop_rdata : p1_sys_ff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_slot_valid_ff <= 1'b0;
			tx_slot_byte_ff  <= '0;
		end else begin
			tx_slot_valid_ff <= tx_p1_ff;
			tx_slot_byte_ff  <= p1_ovh_ff ? ovh_byte : pay_byte;
		end
	end

	// Local per-channel loop and two-entry receive-side buffer
	logic       tail_valid_ff;
	rsb_word_t  tail_word_ff;
	logic       nxt_head_valid;
	logic       nxt_tail_valid;
	rsb_word_t  nxt_head;
	rsb_word_t  nxt_tail;

	wire        push     = sys_rx_valid & sys_rx_ready_ff;
	wire        pop      = rsb_valid_ff & rsb_ready;
	wire        pcm_lp   = pcm_loop_ff[sys_rx_word.slot];
	wire        channel_local_signaling_loop_enable   = sig_loop_ff[sys_rx_word.slot];
	wire rsb_word_t in_word = '{slot: sys_rx_word.slot,
	                            pcm:  pcm_lp ? tsb_pcm : sys_rx_word.pcm,
	                            sig:  channel_local_signaling_loop_enable ? tsb_sig : sys_rx_word.sig};

	always_comb begin
		nxt_head_valid = rsb_valid_ff;
		nxt_head       = rsb_word_ff;
		nxt_tail_valid = tail_valid_ff;
		nxt_tail       = tail_word_ff;
		if (pop) begin
			if (tail_valid_ff) begin
				nxt_head       = tail_word_ff;
				nxt_tail_valid = 1'b0;
			end else begin
				nxt_head_valid = 1'b0;
			end
		end
		if (push) begin
			if (!nxt_head_valid) begin
				nxt_head       = in_word;
				nxt_head_valid = 1'b1;
			end else begin
				nxt_tail       = in_word;
				nxt_tail_valid = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rsb_valid_ff    <= 1'b0;
			rsb_word_ff     <= '0;
			tail_valid_ff   <= 1'b0;
			tail_word_ff    <= '0;
			sys_rx_ready_ff <= 1'b0;
		end else begin
			rsb_valid_ff    <= nxt_head_valid;
			rsb_word_ff     <= nxt_head;
			tail_valid_ff   <= nxt_tail_valid;
			tail_word_ff    <= nxt_tail;
			sys_rx_ready_ff <= ~nxt_tail_valid;
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_line_loop_data: assert property (
		(line_loop && !ais_on) |=> (tx_line_pos_ff == $past(rx_pair.pos)) &&
		                           (tx_line_neg_ff == $past(rx_pair.neg)))
		else $error("line loop data not passed to transmit");
	a_line_loop_clock: assert property (
		line_loop |=> (tx_line_stb_ff == $past(rx_edge)))
		else $error("line loop strobe not taken from receive clock");
	a_ais_marks: assert property (
		(line_loop && ais_on)[*2] |-> (tx_line_pos_ff != tx_line_neg_ff))
		else $error("AIS override not a single mark per bit");
	a_rx_untouched: assert property (
		(line_loop && !framer_loop) |=> (dec_pos_ff == $past(rx_pair.pos)) &&
		                                (dec_stb_ff == $past(rx_edge)))
		else $error("receive path disturbed by line loop");
	a_framer_loop_path: assert property (
		framer_loop |=> (dec_pos_ff == $past(enc_pos)) && (dec_neg_ff == $past(enc_neg)) &&
		                (dec_stb_ff == $past(enc_stb)))
		else $error("framer loop not feeding decoder");
	a_tx_untouched: assert property (
		(framer_loop && !line_loop) |=> (tx_line_pos_ff == $past(enc_pos)) &&
		                                (tx_line_stb_ff == $past(enc_stb)))
		else $error("transmit line disturbed by framer loop");
	a_payload_source: assert property (
		(tx_req_valid && !tx_req.overhead && payload_loop) |->
		##2 (tx_slot_valid_ff && (tx_slot_byte_ff == $past(loop_rdata))))
		else $error("payload loop slot not taken from receive buffer");
	a_overhead_source: assert property (
		(tx_req_valid && tx_req.overhead && !ovh_sys) ##1 !ovh_sys |->
		##1 (tx_slot_byte_ff == $past(tx_req.fmt_byte, 2)))
		else $error("overhead not taken from formatter");
	a_local_pcm_loop: assert property (
		(push && pcm_lp && !rsb_valid_ff) |=> (rsb_word_ff.pcm == $past(tsb_pcm)))
		else $error("local PCM loop not applied");
	a_buffer_holds: assert property (
		(rsb_valid_ff && !rsb_ready) |=> (rsb_valid_ff && $stable(rsb_word_ff)))
		else $error("buffered word lost during stall");
	a_read_latency: assert property (
		rd_hit |-> ##2 reg_rvalid_ff)
		else $error("register read answer late");

	c_both_loops: cover property (line_loop && framer_loop ##1 dec_stb_ff && tx_line_stb_ff);
	c_payload_slot: cover property (payload_loop && tx_req_valid ##2 tx_slot_valid_ff);
	c_buffer_full: cover property (rsb_valid_ff && tail_valid_ff && !sys_rx_ready_ff);
	c_frame_slip: cover property (tx_req_valid && tx_req.first ##1 !rx_frame_end [*3]
		##1 tx_req_valid && tx_req.first);
endmodule

// ### verilog/loopback_pkg.sv
// Constants, register map and carrier types for the framer loopback switch.
// Assumes one 25 MHz clock domain and a byte-wide synchronous register port.
package loopback_pkg;

	localparam int          SLOTS          = 32;
	localparam int          SLOT_W         = 5;
	localparam int          CHAN_REGS      = 64;
	localparam int          CHAN_AW        = 6;

	localparam logic [8:0]  LOOP_CFG_OFS   = 9'h014;
	localparam logic [8:0]  TRANSMIT_FRAMING_CONTROL_OFS       = 9'h072;
	localparam logic [8:0]  SBC_BASE_OFS   = 9'h0e0;
	localparam logic [8:0]  SBC_LAST_OFS   = 9'h0ff;
	localparam logic [8:0]  TPC_BASE_OFS   = 9'h100;
	localparam logic [8:0]  TPC_LAST_OFS   = 9'h11f;

	localparam int          FRAMER_LOOP_BIT  = 0;
	localparam int          LINE_LOOP_BIT    = 1;
	localparam int          PAYLOAD_LOOP_BIT = 2;
	localparam int          AIS_OVR_BIT      = 3;
	localparam int          OVH_FROM_SYS_BIT = 0;
	localparam int          REMOTE_LOOP_BIT  = 0;
	localparam int          LOCAL_PCM_BIT    = 0;
	localparam int          LOCAL_SIG_BIT    = 1;

	localparam logic [7:0]  LOOP_CFG_RST   = 8'h00;
	localparam logic [7:0]  TRANSMIT_FRAMING_CONTROL_RST       = 8'h00;
	localparam logic [7:0]  CHAN_CTRL_RST  = 8'h00;
	localparam logic [7:0]  UNMAPPED_READ  = 8'h00;
	localparam int          READ_LATENCY   = 2;
	localparam int          TX_LATENCY     = 2;

	typedef struct packed {
		logic              pos;
		logic              neg;
	} line_pair_t;

	typedef struct packed {
		logic [SLOT_W-1:0] num;
		logic              overhead;
		logic              first;
		logic [7:0]        fmt_byte;
		logic [7:0]        sys_byte;
	} tx_req_t;

	typedef struct packed {
		logic [SLOT_W-1:0] slot;
		logic [7:0]        pcm;
		logic [3:0]        sig;
	} rsb_word_t;

	typedef enum logic [1:0] {SRC_NONE, SRC_LOOP, SRC_TRANSMIT_FRAMING_CONTROL, SRC_CHAN} rd_src_t;

	function automatic logic chan_hit(input logic [8:0] addr);
		return (addr >= SBC_BASE_OFS) && (addr <= TPC_LAST_OFS);
	endfunction

	function automatic logic [CHAN_AW-1:0] chan_index(input logic [8:0] addr);
		logic [8:0] d;
		d = addr - SBC_BASE_OFS;
		return d[CHAN_AW-1:0];
	endfunction

endpackage
